// ==== rtl/sensor_cfg_defines.vh ====
// Constants for the sensor measurement-control register bank.
// Included by the register bank and its configuration store; definitions only.
`ifndef SENSOR_CFG_DEFINES_VH
`define SENSOR_CFG_DEFINES_VH

// Register addresses.
`define ADDR_COMMAND        8'h80
`define ADDR_PART_ID        8'h81
`define ADDR_PROX_RATE      8'h82
`define ADDR_EMITTER_CUR    8'h83
`define ADDR_LIGHT_PARAM    8'h84

// Command register bit positions.
`define CMD_SELFTIMED_BIT   0
`define CMD_NEAR_EN_BIT     1
`define CMD_LIGHT_EN_BIT    2
`define CMD_NEAR_SINGLE_BIT 3
`define CMD_LIGHT_SINGLE_BIT 4

// Reset values.
`define RST_PROX_RATE       3'h0
`define RST_EMITTER_CODE    6'h02
`define RST_LIGHT_PARAM     8'h0D

// Emitter limits and step.
`define EMITTER_MAX_CODE    6'h14
`define EMITTER_STEP_MA     8'h0A

// Duration of one emulated conversion, in core clock cycles.
`define CONV_CYCLES         8'h20

// Bus receiver states (one-hot).
`define ST_IDLE             6'h01
`define ST_DEVADDR          6'h02
`define ST_REGADDR          6'h04
`define ST_WDATA            6'h08
`define ST_RDATA            6'h10
`define ST_ACK              6'h20

`endif

// ==== rtl/sensor_cfg_store.v ====
// Small register memory holding the writable configuration bytes.
// Assumes the bank above it does the decode; read data come from a register.
`timescale 1ns/1ps
`include "sensor_cfg_defines.vh"
module sensor_cfg_store (
   // Clock and reset.
   input  wire       i_core_clk,
   input  wire       i_rst_n,
   // Write port.
   input  wire       i_wr_en,
   input  wire [1:0] i_wr_idx,
   input  wire [7:0] i_wr_data,
   // Read port.
   input  wire [1:0] i_rd_idx,
   output reg  [7:0] o_rd_data
);
   reg [7:0] mem_r [0:3];
   genvar g;

   // One storage word per entry; reset values keep the device defined after power-up.
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_word
         always @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               if (g == 1)
                  mem_r[g] <= {5'h00, `RST_PROX_RATE};
               else if (g == 2)
                  mem_r[g] <= {2'h0, `RST_EMITTER_CODE};
               else if (g == 3)
                  mem_r[g] <= `RST_LIGHT_PARAM;
               else
                  mem_r[g] <= 8'h00;
            end else if (i_wr_en && (i_wr_idx == g)) begin
               mem_r[g] <= i_wr_data;
            end
         end
      end
   endgenerate

   // Registered read keeps the output free of decode glitches.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_rd_data <= 8'h00;
      else
         o_rd_data <= mem_r[i_rd_idx];
   end
endmodule // sensor_cfg_store

// ==== rtl/sensor_cfg_regs.v ====
// Measurement-control register bank of an optical proximity and light sensor.
// Assumes an I2C master on scl/sda; sda is open drain, resolved outside.
// Notes on behaviour
// - Both single-request bits start both conversions together.
// - Self-timed mode ignores single requests; needs enables.
// - Identification register reads fixed code, ignores writes.
// - Proximity rate holds three-bit code, upper unused.
// - Emitter register holds writable six-bit current code.
// - Emitter current is code times 10 mA.
// - Codes above twenty saturate at 200 mA.
// - Top two emitter bits read calibration tag.
// - Emitter writes made in self-timed mode apply once it stops.
// - Light parameter register fields as documented.
// - Bit 0 starts timer; periodic per enable bits.
`timescale 1ns/1ps
`include "sensor_cfg_defines.vh"
module sensor_cfg_regs #(
   parameter [6:0] DEV_ADDR  = 7'h13,  // Bus address; arbitrary value.
   parameter [3:0] PRODUCT   = 4'h5,   // Arbitrary product code.
   parameter [3:0] REVISION  = 4'h3,   // Arbitrary revision code.
   parameter [1:0] CAL_TAG   = 2'h1    // Arbitrary calibration tag.
) (
   // Clock and reset.
   input  wire       i_core_clk,
   input  wire       i_rst_n,
   // I2C pins.
   input  wire       i_scl,
   input  wire       i_sda,
   output reg        o_sda,
   output reg        o_sda_oe_n,
   // Measurement control.
   output reg  [7:0] o_emitter_ma,
   output reg  [2:0] o_near_rate,
   output reg  [7:0] o_light_param,
   output reg        o_timer_run,
   output reg        o_near_conv,
   output reg        o_light_conv
);
   reg  [2:0] scl_sync_r;
   reg  [2:0] sda_sync_r;
   reg        scl_r;
   reg        sda_r;
   reg  [5:0] state_r;
   reg  [3:0] bit_cnt_r;
   reg  [7:0] shift_r;
   reg        rnw_r;
   reg        addr_ok_r;
   reg        ack_wr_r;
   reg  [7:0] reg_addr_r;
   reg        ack_phase_r;
   reg  [7:0] cmd_r;
   reg  [5:0] emit_live_r;
   reg  [7:0] near_cnt_r;
   reg  [7:0] light_cnt_r;
   reg        wr_pulse_r;
   reg  [7:0] wr_data_r;
   reg  [2:0] near_pend_r;
   reg  [5:0] emit_pend_r;
   reg  [7:0] light_pend_r;
   reg  [7:0] rd_byte;
   wire [7:0] store_rd;
   wire       scl_f;
   wire       sda_f;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_c;
   wire       stop_c;
   wire       hit_store;

   // Three-stage synchronisers; a level counts once stages two and three agree.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
         scl_r      <= 1'b1;
         sda_r      <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[1:0], i_scl};
         sda_sync_r <= {sda_sync_r[1:0], i_sda};
         if (scl_sync_r[1] == scl_sync_r[2])
            scl_r <= scl_sync_r[2];
         if (sda_sync_r[1] == sda_sync_r[2])
            sda_r <= sda_sync_r[2];
      end
   end

   assign scl_f    = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_r;
   assign sda_f    = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_r;
   assign scl_rise = scl_f & ~scl_r;
   assign scl_fall = ~scl_f & scl_r;
   // Start and stop are sda edges while scl stays high.
   assign start_c  = scl_r & scl_f & sda_r & ~sda_f;
   assign stop_c   = scl_r & scl_f & ~sda_r & sda_f;
   assign hit_store = (reg_addr_r >= `ADDR_PROX_RATE) && (reg_addr_r <= `ADDR_LIGHT_PARAM);

   sensor_cfg_store u_store (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_wr_en    (wr_pulse_r && hit_store),
      .i_wr_idx   (wr_addr_idx(reg_addr_r)),
      .i_wr_data  (wr_data_r),
      .i_rd_idx   (wr_addr_idx(reg_addr_r)),
      .o_rd_data  (store_rd)
   );

   // Entry 1 holds the proximity rate, entry 2 the emitter code, entry 3 the light parameters.
   function [1:0] wr_addr_idx;
      input [7:0] a;
      begin
         wr_addr_idx = a[1:0] + 2'h3; // 82h..84h land on entries 1..3.
      end
   endfunction

   // Latest host value of each setting; the store's one read port follows the pointer,
   // so the values to be taken into use are kept here where they can be read at any time.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         near_pend_r  <= `RST_PROX_RATE;
         emit_pend_r  <= `RST_EMITTER_CODE;
         light_pend_r <= `RST_LIGHT_PARAM;
      end else if (wr_pulse_r) begin
         if (reg_addr_r == `ADDR_PROX_RATE)
            near_pend_r <= wr_data_r[2:0];
         else if (reg_addr_r == `ADDR_EMITTER_CUR)
            emit_pend_r <= wr_data_r[5:0];
         else if (reg_addr_r == `ADDR_LIGHT_PARAM)
            light_pend_r <= wr_data_r;
      end
   end

   // Read multiplexer; fixed fields are overlaid so writes to them cannot stick.
   always @* begin
      rd_byte = 8'h00;
      if (reg_addr_r == `ADDR_COMMAND)
         rd_byte = {3'h4, cmd_r[4:0]};
      else if (reg_addr_r == `ADDR_PART_ID)
         rd_byte = {PRODUCT, REVISION};
      else if (reg_addr_r == `ADDR_PROX_RATE)
         rd_byte = {5'h00, store_rd[2:0]};
      else if (reg_addr_r == `ADDR_EMITTER_CUR)
         rd_byte = {CAL_TAG, store_rd[5:0]};
      else if (reg_addr_r == `ADDR_LIGHT_PARAM)
         rd_byte = store_rd;
   end

   // Byte-level I2C slave; address byte, register pointer, then data bytes.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r     <= `ST_IDLE;
         bit_cnt_r   <= 4'h0;
         shift_r     <= 8'h00;
         rnw_r       <= 1'b0;
         addr_ok_r   <= 1'b0;
         ack_wr_r    <= 1'b0;
         reg_addr_r  <= 8'h00;
         ack_phase_r <= 1'b0;
         o_sda       <= 1'b1;
         o_sda_oe_n  <= 1'b1;
         wr_pulse_r  <= 1'b0;
         wr_data_r   <= 8'h00;
      end else begin
         wr_pulse_r <= 1'b0;
         if (start_c) begin
            state_r    <= `ST_DEVADDR;
            bit_cnt_r  <= 4'h0;
            o_sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            state_r    <= `ST_IDLE;
            o_sda_oe_n <= 1'b1;
         end else begin
            case (state_r)
               `ST_DEVADDR, `ST_REGADDR, `ST_WDATA: begin
                  if (scl_rise) begin
                     shift_r   <= {shift_r[6:0], sda_f};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
                  if (scl_fall && bit_cnt_r == 4'h8) begin
                     bit_cnt_r <= 4'h0;
                     ack_wr_r  <= 1'b1;
                     if (state_r == `ST_DEVADDR) begin
                        addr_ok_r <= (shift_r[7:1] == DEV_ADDR);
                        rnw_r     <= shift_r[0];
                        ack_wr_r  <= (shift_r[7:1] == DEV_ADDR);
                     end else if (state_r == `ST_REGADDR) begin
                        reg_addr_r <= shift_r;
                     end else begin
                        wr_data_r  <= shift_r;
                        wr_pulse_r <= 1'b1;
                     end
                     o_sda      <= 1'b0;
                     o_sda_oe_n <= ~((state_r != `ST_DEVADDR) | (shift_r[7:1] == DEV_ADDR));
                     ack_phase_r <= 1'b0;
                     // A foreign device address leaves the bank silent until the next start.
                     state_r    <= (state_r == `ST_DEVADDR && shift_r[7:1] != DEV_ADDR) ? `ST_IDLE : `ST_ACK;
                  end
               end
               `ST_ACK: begin
                  if (scl_fall) begin
                     o_sda_oe_n <= 1'b1;
                     // A read address hands over the first data bit on this falling edge.
                     if (addr_ok_r && rnw_r) begin
                        state_r    <= `ST_RDATA;
                        shift_r    <= rd_byte;
                        o_sda      <= rd_byte[7];
                        o_sda_oe_n <= rd_byte[7];
                        bit_cnt_r  <= 4'h1;
                     end else if (reg_addr_r == reg_addr_r && ack_wr_r && !ack_phase_r &&
                                  bit_cnt_r == 4'h0 && state_r == `ST_ACK) begin
                        state_r <= rnw_r ? `ST_IDLE : (addr_ok_r ? `ST_REGADDR : `ST_IDLE);
                     end
                     addr_ok_r <= 1'b0;
                     if (!addr_ok_r && !rnw_r)
                        state_r <= `ST_WDATA;
                     if (!addr_ok_r && rnw_r && !ack_phase_r)
                        state_r <= `ST_IDLE;
                  end
               end
               `ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_r == 4'h8) begin
                        o_sda_oe_n <= 1'b1;
                        bit_cnt_r  <= 4'h9;
                     end else if (bit_cnt_r == 4'h9) begin
                        state_r <= `ST_IDLE;                    // One byte per read, then release.
                     end else begin
                        o_sda      <= shift_r[7 - bit_cnt_r[2:0]];
                        o_sda_oe_n <= shift_r[7 - bit_cnt_r[2:0]];
                        bit_cnt_r  <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               default: begin
                  o_sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // Command register; single requests are dropped while the timer runs.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_r <= 8'h00;
      end else begin
         if (wr_pulse_r && reg_addr_r == `ADDR_COMMAND) begin
            cmd_r[2:0] <= wr_data_r[2:0];
            if (!cmd_r[`CMD_SELFTIMED_BIT] && !wr_data_r[`CMD_SELFTIMED_BIT]) begin
               cmd_r[`CMD_NEAR_SINGLE_BIT]  <= wr_data_r[`CMD_NEAR_SINGLE_BIT] | cmd_r[3];
               cmd_r[`CMD_LIGHT_SINGLE_BIT] <= wr_data_r[`CMD_LIGHT_SINGLE_BIT] | cmd_r[4];
            end
         end else begin
            // End of a single conversion; a write in the same cycle keeps its request.
            if (near_cnt_r == 8'h01)
               cmd_r[`CMD_NEAR_SINGLE_BIT] <= 1'b0;
            if (light_cnt_r == 8'h01 && !o_light_param[7])
               cmd_r[`CMD_LIGHT_SINGLE_BIT] <= 1'b0;
         end
      end
   end

   // Conversion timers and the latched emitter setting.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         near_cnt_r    <= 8'h00;
         light_cnt_r   <= 8'h00;
         emit_live_r   <= `RST_EMITTER_CODE;
         o_emitter_ma  <= `RST_EMITTER_CODE * `EMITTER_STEP_MA;
         o_near_rate   <= `RST_PROX_RATE;
         o_light_param <= `RST_LIGHT_PARAM;
         o_timer_run   <= 1'b0;
         o_near_conv   <= 1'b0;
         o_light_conv  <= 1'b0;
      end else begin
         o_timer_run <= cmd_r[`CMD_SELFTIMED_BIT];
         // Settings are taken into use only while the timer is off, so a running
         // self-timed measurement never sees a half-changed setting.
         if (!cmd_r[`CMD_SELFTIMED_BIT]) begin
            emit_live_r <= emit_pend_r;
            o_near_rate <= near_pend_r;
         end
         if (!cmd_r[`CMD_LIGHT_SINGLE_BIT] && !cmd_r[`CMD_SELFTIMED_BIT])
            o_light_param <= light_pend_r;
         o_emitter_ma <= (emit_live_r > `EMITTER_MAX_CODE) ?
                         (`EMITTER_MAX_CODE * `EMITTER_STEP_MA) :
                         ({2'h0, emit_live_r} * `EMITTER_STEP_MA);
         // A single request reloads its timer whenever it is idle; its bit clears on the last count, the light one only while o_light_param[7] is low.
         if (cmd_r[`CMD_NEAR_SINGLE_BIT] && near_cnt_r == 8'h00)
            near_cnt_r <= `CONV_CYCLES;
         else if (near_cnt_r != 8'h00)
            near_cnt_r <= near_cnt_r - 8'h01;
         if (cmd_r[`CMD_LIGHT_SINGLE_BIT] && light_cnt_r == 8'h00)
            light_cnt_r <= `CONV_CYCLES;
         else if (light_cnt_r != 8'h00)
            light_cnt_r <= light_cnt_r - 8'h01;
         // Periodic enables hold the flags high for as long as the timer runs.
         o_near_conv  <= (near_cnt_r != 8'h00) |
                         (cmd_r[0] & cmd_r[`CMD_NEAR_EN_BIT]);
         o_light_conv <= (light_cnt_r != 8'h00) |
                         (cmd_r[0] & cmd_r[`CMD_LIGHT_EN_BIT]);
      end
   end
endmodule // sensor_cfg_regs

// ==== dv/sensor_cfg_regs_assertions.sv ====
// Pin-level checks for the sensor register bank.
// Bound to sensor_cfg_regs; sees its ports only.
`timescale 1ns/1ps
`include "sensor_cfg_defines.vh"
module sensor_cfg_regs_assertions (
   // Clock, reset and bus.
   input logic       i_core_clk,
   input logic       i_rst_n,
   input logic       i_scl,
   input logic       o_sda,
   input logic       o_sda_oe_n,
   // Control outputs.
   input logic [7:0] o_emitter_ma,
   input logic [2:0] o_near_rate,
   input logic [7:0] o_light_param,
   input logic       o_timer_run,
   input logic       o_near_conv,
   input logic       o_light_conv
);
   logic [7:0] len_r;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // Length of a proximity conversion; an exact count exposes an off-by-one in its timer.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) len_r <= 8'h00;
      else len_r <= o_near_conv ? len_r + 8'h01 : 8'h00;
   end
   // Settings in use stay put while self-timed mode runs.
   a_emitter_hold: assert property (o_timer_run && $past(o_timer_run) |-> $stable(o_emitter_ma))
      else $error("emitter moved while timer ran");
   a_rate_hold: assert property (o_timer_run && $past(o_timer_run) |-> $stable(o_near_rate))
      else $error("rate moved while timer ran");
   a_light_hold: assert property (o_timer_run && $past(o_timer_run) |-> $stable(o_light_param))
      else $error("light parameters moved while timer ran");
   // Emitter drive is whole steps of ten and never above the ceiling.
   a_emitter_cap: assert property (o_emitter_ma <= 8'hC8)
      else $error("emitter current above ceiling");
   a_emitter_step: assert property (o_emitter_ma % 8'h0A == 8'h00)
      else $error("emitter current not a whole step");
   a_near_len: assert property ($fell(o_near_conv) && !o_timer_run |-> len_r == `CONV_CYCLES)
      else $error("single conversion length wrong");
   // Open-drain data: only pull low, and switch the drive only while scl is low.
   a_sda_pull: assert property (!o_sda_oe_n |-> !o_sda)
      else $error("sda driven high");
   a_ack_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
      else $error("sda drive changed with scl high");
   c_both_conv: cover property ($rose(o_near_conv) && $rose(o_light_conv));
   c_timer_on: cover property ($rose(o_timer_run));
   c_ack: cover property ($fell(o_sda_oe_n));
endmodule // sensor_cfg_regs_assertions

// ==== dv/i2c_host_model.sv ====
// I2C host model reaching the register bank one byte per transaction.
// Assumes a pull-up on sda, so the line is the AND of all drivers.
`timescale 1ns/1ps
module i2c_host_model (
   // Pacing clock.
   input  logic i_core_clk,
   // Bus lines.
   input  logic i_sda_line,
   output logic o_scl,
   output logic o_sda_drv
);
   logic [7:0] junk;
   int         pace;
   // Idle bus: both lines released high.
   initial begin
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
      pace = 5;
   end
   // One bus phase; at least five cycles keeps each pin change past the bank's filter.
   task automatic step(input logic c, input logic s);
      o_scl = c;
      o_sda_drv = s;
      repeat (pace) @(posedge i_core_clk);
      #1;
   endtask
   // Sda moves only while scl is low; the line is read just before scl falls.
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      r = i_sda_line;
      step(1'b0, b);
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
   endtask
   // Start or repeated start, and stop.
   task automatic start;
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop;
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   // Pointer byte, then one data byte written, or read after a repeated start and closed by nack.
   task automatic xfer(input logic [6:0] dev, input logic rd, input logic [7:0] ptr, input logic [7:0] d,
                       output logic [7:0] r, output logic nak);
      logic a0, a1, a2, an;
      // Every transaction starts just after a clock edge, whatever the caller's timing.
      @(posedge i_core_clk);
      #1;
      start;
      byte_io({dev, 1'b0}, junk);
      bit_io(1'b1, a0);
      byte_io(ptr, junk);
      bit_io(1'b1, a1);
      if (rd) begin
         start;
         byte_io({dev, 1'b1}, junk);
         bit_io(1'b1, a2);
         byte_io(8'hFF, r);
         bit_io(1'b1, an);
      end else begin
         byte_io(d, junk);
         bit_io(1'b1, a2);
      end
      stop;
      nak = a0 | a1 | a2;
   endtask
endmodule // i2c_host_model

// ==== dv/sensor_cfg_regs_bench.sv ====
// Self-checking bench for the sensor register bank, driven by the I2C host model.
// Assumes the defines header is on the include path; sda carries a pull-up.
`timescale 1ns/1ps
`include "sensor_cfg_defines.vh"
module sensor_cfg_regs_bench;
   localparam logic [6:0] BUS = 7'h2A;  // Arbitrary bus address.
   localparam logic [3:0] PRD = 4'h6;   // Arbitrary product code.
   localparam logic [3:0] REV = 4'h4;   // Arbitrary revision code.
   localparam logic [1:0] TAG = 2'h2;   // Arbitrary calibration tag.
   logic       clk, rst_n, scl, sda_drv, sda_out, sda_oe_n, timer_run, near_conv, light_conv, nak, seen;
   logic [7:0] emit_ma, light_param, lfsr, d, got;
   logic [2:0] near_rate;
   int         mismatches, total_checks, k;
   wire        sda_line = sda_drv & (sda_oe_n | sda_out);
   sensor_cfg_regs #(.DEV_ADDR(BUS), .PRODUCT(PRD), .REVISION(REV), .CAL_TAG(TAG)) DUT (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_out),
      .o_sda_oe_n(sda_oe_n), .o_emitter_ma(emit_ma), .o_near_rate(near_rate), .o_light_param(light_param),
      .o_timer_run(timer_run), .o_near_conv(near_conv), .o_light_conv(light_conv));
   i2c_host_model host (.i_core_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_drv(sda_drv));
   // Clock at 40 MHz.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Expected values, worked out from the register layout.
   function automatic logic [7:0] next_rand(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] emit_exp(input logic [7:0] w);
      return (w[5:0] > 6'h14) ? 8'hC8 : {2'h0, w[5:0]} * 8'h0A;
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Bus wrappers; a write that is not acknowledged is a mismatch.
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      host.xfer(BUS, 1'b0, p, v, got, nak);
      chk({7'h00, nak}, 8'h00);
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      host.xfer(BUS, 1'b1, p, 8'h00, got, nak);
      chk(got, e);
   endtask
   task automatic conclude;
      if (mismatches == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence; rates change only with the timer off and no single request pending.
   initial begin
      rst_n = 1'b0;
      lfsr = 8'h29;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      chk(emit_ma, 8'h14);
      chk({5'h00, near_rate}, 8'h00);
      chk(light_param, 8'h0D);
      repeat (4) @(posedge clk);
      rd(`ADDR_PART_ID, {PRD, REV});
      wr(`ADDR_PART_ID, 8'hFF);
      rd(`ADDR_PART_ID, {PRD, REV});
      rd(`ADDR_EMITTER_CUR, {TAG, 6'h02});
      for (int i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         d = (i == 0) ? 8'h15 : (i == 1) ? 8'hD4 : lfsr;
         wr(`ADDR_EMITTER_CUR, d);
         rd(`ADDR_EMITTER_CUR, {TAG, d[5:0]});
         chk(emit_ma, emit_exp(d));
         wr(`ADDR_PROX_RATE, d);
         host.xfer(BUS, 1'b1, `ADDR_PROX_RATE, 8'h00, got, nak);
         chk({5'h00, got[2:0]}, {5'h00, d[2:0]});
         chk({5'h00, near_rate}, {5'h00, d[2:0]});
         wr(`ADDR_LIGHT_PARAM, ~d);
         rd(`ADDR_LIGHT_PARAM, ~d);
         chk(light_param, ~d);
      end
      wr(`ADDR_LIGHT_PARAM, 8'h0D);
      // Slower host: unmapped place, then a foreign bus address.
      host.pace = 9;
      wr(8'h9C, 8'h5A);
      rd(8'h9C, 8'h00);
      host.xfer(~BUS, 1'b0, `ADDR_PROX_RATE, 8'h07, got, nak);
      chk({7'h00, nak}, 8'h01);
      chk({5'h00, near_rate}, {5'h00, d[2:0]});
      // Both single requests in one write start both conversions at once.
      fork
         wr(`ADDR_COMMAND, 8'h18);
         begin
            for (k = 0; k < 1000 && near_conv !== 1'b1; k++) @(posedge clk) #1;
            chk({6'h00, near_conv, light_conv}, 8'h03);
         end
      join
      // Self-timed mode without periodic enables ignores single requests.
      wr(`ADDR_COMMAND, 8'h01);
      chk({7'h00, timer_run}, 8'h01);
      seen = 1'b0;
      fork
         wr(`ADDR_COMMAND, 8'h19);
         for (k = 0; k < 900; k++) @(posedge clk) seen = seen | near_conv | light_conv;
      join
      chk({7'h00, seen}, 8'h00);
      // Emitter write while running waits until the mode is cycled.
      wr(`ADDR_EMITTER_CUR, 8'h05);
      chk(emit_ma, emit_exp(d));
      wr(`ADDR_COMMAND, 8'h00);
      wr(`ADDR_COMMAND, 8'h01);
      chk(emit_ma, 8'h32);
      conclude;
   end
   // Watchdog well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      conclude;
   end
endmodule // sensor_cfg_regs_bench
bind sensor_cfg_regs sensor_cfg_regs_assertions u_chk (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
   .o_emitter_ma(o_emitter_ma), .o_near_rate(o_near_rate), .o_light_param(o_light_param),
   .o_timer_run(o_timer_run), .o_near_conv(o_near_conv), .o_light_conv(o_light_conv));
